// ==== fsltun_core.sv ====
// How it works
// - Limiter off: direct modes jump to each new setting.
// - Limiter on: direct changes capped at max step per update.
// - Tach glitch filter on while its bit is one.
// - Derivative: none, basic, uncapped step, or both.
// - Step derivative bypasses the max-step cap.
// - Inside deadband, corrections are discarded.
// - Deadband codes: 0, 50, 100, 200 RPM.
// - Three 2-bit gains decode to 1x, 2x, 4x, 8x.
// - Drive-fail window: off, 16, 32, 64 updates.
// - No skip-kick: full duty for first quarter of spin-up.
// - Skip-kick: spin level for whole spin-up.
// - Spin level 30% to 65% in 5% steps.
// - Spin-up 250ms to 2s; no valid tach interrupts.
// - Loop active: failed spin-up retries at once.
// - 6-bit max step limits change per update, except the step derivative.
// - Loop corrections hold drive at or above floor unless target all ones; spin-up levels ignore it.
// - Fan stall while running restarts it.
// - Tuning, spin-up, step, floor registers obey the lock.
// - Update interval 100ms to 1600ms.
// - Full drive below target band for window sets fail.
`timescale 1ns/1ps
module fsltun_core
  import fsltun_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  output logic      [7:0]        reg_rdata,
  // Mode and lock
  input  wire logic              speed_loop_en,
  input  wire logic              direct_mode_en,
  input  wire logic              sw_lock,
  input  wire logic [2:0]        upd_code,
  // Setpoints and measurement
  input  wire logic [7:0]        direct_setting,
  input  wire logic [7:0]        tach_target_hi,
  input  wire logic signed [15:0] rpm_error,
  input  wire logic              tach_valid,
  input  wire logic              fan_stalled,
  input  wire logic              below_fail_band,
  input  wire logic              drive_fail_clr,
  // Fan side
  input  wire logic              tach_in,
  output logic                   tach_filtered,
  output logic      [7:0]        drive_setting,
  // Status
  output logic                   spinning_up,
  output logic                   spin_fail_irq,
  output logic                   drive_fail_irq,
  output logic                   drive_fail_status
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1_r;
  logic rst_sync_b;

  // Two-stage release; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1_r   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_q1_r   <= 1'b1;
      rst_sync_b <= rst_q1_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] tune_r;
  logic [7:0] gain_r;
  logic [7:0] spin_r;
  logic [7:0] step_r;
  logic [7:0] floor_r;
  logic       lock_r;
  logic       wr_ok;

  // Lock is sticky until reset
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b)  lock_r <= 1'b0;
    else if (sw_lock) lock_r <= 1'b1;
  end

  assign wr_ok = reg_wr & ~lock_r;

  // Register writes; reserved bits kept at zero
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tune_r  <= RST_TUNE;
      gain_r  <= RST_GAIN;
      spin_r  <= RST_SPIN;
      step_r  <= RST_STEP;
      floor_r <= RST_FLOOR;
    end else if (wr_ok) begin
      unique case (reg_addr)
        OFS_TUNE:  tune_r  <= reg_wdata & MASK_TUNE;
        OFS_GAIN:  gain_r  <= reg_wdata & MASK_GAIN;
        OFS_SPIN:  spin_r  <= reg_wdata;
        OFS_STEP:  step_r  <= reg_wdata & MASK_STEP;
        OFS_FLOOR: floor_r <= reg_wdata;
        default:   ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      OFS_TUNE:  reg_rdata = tune_r;
      OFS_GAIN:  reg_rdata = gain_r;
      OFS_SPIN:  reg_rdata = spin_r;
      OFS_STEP:  reg_rdata = step_r;
      OFS_FLOOR: reg_rdata = floor_r;
      default:   reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic       ramp_en;
  logic       glitch_en;
  logic [1:0] der_sel;
  logic [1:0] band_sel;
  logic [1:0] gp;
  logic [1:0] gi;
  logic [1:0] gd;
  logic [1:0] fail_sel;
  logic       skip_kick;
  logic [2:0] lvl_sel;
  logic [1:0] time_sel;
  logic [7:0] lvl_drive;
  logic [11:0] spin_total;
  logic [11:0] kick_total;
  logic [6:0] fail_win;
  logic [15:0] band_rpm;

  assign ramp_en   = tune_r[TUNE_RAMP_BIT];
  assign glitch_en = tune_r[TUNE_GLITCH_BIT];
  assign der_sel   = tune_r[TUNE_DER_LSB +: 2];
  assign band_sel  = tune_r[TUNE_BAND_LSB +: 2];
  assign gp        = gain_r[GAIN_P_LSB +: 2];
  assign gi        = gain_r[GAIN_I_LSB +: 2];
  assign gd        = gain_r[GAIN_D_LSB +: 2];
  assign fail_sel  = spin_r[SPIN_FAIL_LSB +: 2];
  assign skip_kick = spin_r[SPIN_KICK_BIT];
  assign lvl_sel   = spin_r[STARTUP_DRIVE_LEVEL_LSB +: 3];
  assign time_sel  = spin_r[SPIN_TIME_LSB +: 2];

  // Spin level as a duty value out of full scale
  assign lvl_drive = 8'((
    (LVL_BASE_PCT + LVL_STEP_PCT * int'(lvl_sel)) * 255) / 100);
  assign spin_total = spin_ms(time_sel);
  assign kick_total = 12'(int'(spin_total) / KICK_DIV);
  // Window 16 << (code-1); code zero disables
  assign fail_win  = (fail_sel == 2'd0) ? 7'd0 :
                     7'(FAIL_WIN_BASE << (fail_sel - 2'd1));

  // Deadband half-width in RPM
  always_comb begin
    unique case (band_sel)
      2'd0: band_rpm = 16'd0;
      2'd1: band_rpm = 16'd50;
      2'd2: band_rpm = 16'd100;
      2'd3: band_rpm = 16'd200;
    endcase
  end

  // ----------------------------------------
  // Timebase and tach filter
  // ----------------------------------------
  logic ms_tick;
  logic upd_tick;

  fsltun_tick #(.TICKS(TICKS)) u_tick (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .upd_code   (upd_code),
    .ms_tick    (ms_tick),
    .upd_tick   (upd_tick)
  );

  fsltun_glitch u_glitch (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .en         (glitch_en),
    .tach_in    (tach_in),
    .tach_out   (tach_filtered)
  );

  // ----------------------------------------
  // Spin-up sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {ST_OFF, ST_KICK, ST_SPIN, ST_RUN} fsltun_st_e;
  fsltun_st_e st_r;
  logic [11:0] spin_cnt_r;
  logic        loop_on;
  logic        tgt_off;

  assign tgt_off = (tach_target_hi == TARGET_OFF);
  assign loop_on = speed_loop_en & ~tgt_off;
  assign spinning_up = (st_r == ST_KICK) | (st_r == ST_SPIN);

  // Sequencer; leaving target-off or a stall restarts the fan
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r          <= ST_OFF;
      spin_cnt_r    <= '0;
      spin_fail_irq <= 1'b0;
    end else begin
      spin_fail_irq <= 1'b0;
      if (!loop_on) begin
        st_r       <= ST_OFF;
        spin_cnt_r <= '0;
      end else begin
        unique case (st_r)
          ST_OFF, ST_RUN: begin
            if (st_r == ST_OFF || fan_stalled) begin
              st_r       <= skip_kick ? ST_SPIN : ST_KICK;
              spin_cnt_r <= '0;
            end
          end
          ST_KICK, ST_SPIN: begin
            if (ms_tick) spin_cnt_r <= spin_cnt_r + 12'd1;
            if (st_r == ST_KICK && ms_tick &&
                spin_cnt_r + 12'd1 >= kick_total)
              st_r <= ST_SPIN;
            if (ms_tick && spin_cnt_r + 12'd1 >= spin_total) begin
              spin_cnt_r <= '0;
              if (tach_valid) begin
                st_r <= ST_RUN;
              end else begin
                spin_fail_irq <= 1'b1;
                st_r <= skip_kick ? ST_SPIN : ST_KICK;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // PID correction
  // ----------------------------------------
  logic signed [15:0] prev_err_r;
  logic signed [23:0] integ_r;
  logic signed [23:0] p_term;
  logic signed [23:0] i_term;
  logic signed [23:0] d_term;
  logic signed [23:0] capped;
  logic signed [23:0] delta;
  logic signed [23:0] step_s;
  logic signed [23:0] sum_pid;
  logic signed [23:0] abs_err;
  logic               in_band;

  // Gains are shifts of 0..3: 1x, 2x, 4x, 8x
  assign p_term = (24'(rpm_error) <<< gp) >>> 6;
  assign i_term = (integ_r <<< gi) >>> 10;
  assign d_term = (24'(rpm_error - prev_err_r) <<< gd) >>> 6;
  assign step_s = 24'(step_r[5:0]);
  assign abs_err = rpm_error < 0 ? -24'(rpm_error) : 24'(rpm_error);
  assign in_band = abs_err <= 24'(band_rpm);

  // Basic derivative joins the capped sum; step derivative skips cap
  always_comb begin
    sum_pid = p_term + i_term;
    if (der_sel[0]) sum_pid = sum_pid + d_term;
    if (sum_pid > step_s)
      capped = step_s;
    else if (sum_pid < -step_s)
      capped = -step_s;
    else
      capped = sum_pid;
    delta = capped;
    if (der_sel[1]) delta = capped + d_term;
  end

  // Error history, updated every interval even inside the band
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prev_err_r <= '0;
      integ_r    <= '0;
    end else if (st_r != ST_RUN) begin
      prev_err_r <= '0;
      integ_r    <= '0;
    end else if (upd_tick) begin
      prev_err_r <= rpm_error;
      integ_r    <= integ_r + 24'(rpm_error);
    end
  end

  // ----------------------------------------
  // Drive output
  // ----------------------------------------
  logic signed [23:0] loop_next;
  logic        [7:0]  loop_drive;
  logic        [7:0]  ramp_drive;
  logic        [8:0]  up_sum;

  // Saturate, then hold the floor
  always_comb begin
    loop_next = 24'(drive_setting) + delta;
    if (loop_next > 24'sd255)
      loop_drive = DRIVE_FULL;
    else if (loop_next < 24'sd0)
      loop_drive = 8'h00;
    else
      loop_drive = loop_next[7:0];
    if (loop_drive < floor_r) loop_drive = floor_r;
  end

  // Direct mode ramp one step toward the request
  always_comb begin
    up_sum = {1'b0, drive_setting} + {3'b000, step_r[5:0]};
    if (direct_setting > drive_setting)
      ramp_drive = (up_sum[8] || up_sum[7:0] > direct_setting) ?
                   direct_setting : up_sum[7:0];
    else if (drive_setting - direct_setting > {2'b00, step_r[5:0]})
      ramp_drive = drive_setting - {2'b00, step_r[5:0]};
    else
      ramp_drive = direct_setting;
  end

  // Drive register; the loop overrides direct mode when both are set
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      drive_setting <= 8'h00;
    end else if (speed_loop_en) begin
      if (tgt_off)
        drive_setting <= 8'h00;
      else if (st_r == ST_KICK)
        drive_setting <= DRIVE_FULL;
      else if (st_r == ST_SPIN)
        drive_setting <= lvl_drive;
      else if (st_r == ST_RUN && upd_tick && !in_band)
        drive_setting <= loop_drive;
    end else if (direct_mode_en) begin
      if (!ramp_en)
        drive_setting <= direct_setting;
      else if (upd_tick)
        drive_setting <= ramp_drive;
    end
  end

  // ----------------------------------------
  // Drive-fail detection
  // ----------------------------------------
  logic [6:0] fail_cnt_r;
  logic       fail_hit;

  assign fail_hit = upd_tick && below_fail_band && fail_win != 7'd0 &&
                    st_r == ST_RUN && drive_setting == DRIVE_FULL &&
                    (fail_cnt_r + 7'd1 >= fail_win);

  // Counts update periods spent short of target at full drive
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fail_cnt_r <= '0;
    end else if (fail_win == 7'd0 || st_r != ST_RUN ||
                 drive_setting != DRIVE_FULL) begin
      fail_cnt_r <= '0;
    end else if (upd_tick) begin
      if (!below_fail_band || fail_hit) fail_cnt_r <= '0;
      else                              fail_cnt_r <= fail_cnt_r + 7'd1;
    end
  end

  // Sticky flag; a new failure wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      drive_fail_status <= 1'b0;
      drive_fail_irq    <= 1'b0;
    end else begin
      drive_fail_irq <= 1'b0;
      if (fail_hit) begin
        drive_fail_status <= 1'b1;
        drive_fail_irq    <= 1'b1;
      end else if (drive_fail_clr) begin
        drive_fail_status <= 1'b0;
      end
    end
  end

endmodule : fsltun_core

// ==== fsltun_pkg.sv ====
package fsltun_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_TUNE  = 8'h43;
  localparam logic [7:0] OFS_GAIN  = 8'h45;
  localparam logic [7:0] OFS_SPIN  = 8'h46;
  localparam logic [7:0] OFS_STEP  = 8'h47;
  localparam logic [7:0] OFS_FLOOR = 8'h48;

  // ----------------------------------------
  // Values after reset and read masks
  // ----------------------------------------
  localparam logic [7:0] RST_TUNE   = 8'h38;
  localparam logic [7:0] RST_GAIN   = 8'h2a;
  localparam logic [7:0] RST_SPIN   = 8'h19;
  localparam logic [7:0] RST_STEP   = 8'h10;
  localparam logic [7:0] RST_FLOOR  = 8'h66;
  localparam logic [7:0] MASK_TUNE  = 8'h7e;
  localparam logic [7:0] MASK_GAIN  = 8'h3f;
  localparam logic [7:0] MASK_STEP  = 8'h3f;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TUNE_RAMP_BIT   = 6;
  localparam int TUNE_GLITCH_BIT = 5;
  localparam int TUNE_DER_LSB    = 3;
  localparam int TUNE_BAND_LSB   = 1;
  localparam int GAIN_P_LSB      = 0;
  localparam int GAIN_I_LSB      = 2;
  localparam int GAIN_D_LSB      = 4;
  localparam int SPIN_FAIL_LSB   = 6;
  localparam int SPIN_KICK_BIT   = 5;
  localparam int STARTUP_DRIVE_LEVEL_LSB    = 2;
  localparam int SPIN_TIME_LSB   = 0;

  // ----------------------------------------
  // Drive levels and timing
  // ----------------------------------------
  localparam logic [7:0] DRIVE_FULL  = 8'hff;
  localparam logic [7:0] TARGET_OFF  = 8'hff;
  localparam int LVL_BASE_PCT        = 30;
  localparam int LVL_STEP_PCT        = 5;
  localparam int KICK_DIV            = 4;
  localparam int CLK_HZ              = 25_000_000;
  localparam int TICK_MS             = 1;
  localparam int TICK_CYCLES         = CLK_HZ / 1000 * TICK_MS;
  localparam int FILT_DEPTH          = 3;
  localparam int FAIL_WIN_BASE       = 16;

  // Update interval in ms, code 0..7
  function automatic logic [10:0] upd_ms(input logic [2:0] c);
    unique case (c)
      3'h0: upd_ms = 11'd100;
      3'h1: upd_ms = 11'd200;
      3'h2: upd_ms = 11'd300;
      3'h3: upd_ms = 11'd400;
      3'h4: upd_ms = 11'd500;
      3'h5: upd_ms = 11'd800;
      3'h6: upd_ms = 11'd1200;
      3'h7: upd_ms = 11'd1600;
    endcase
  endfunction : upd_ms

  // Total spin-up time in ms
  function automatic logic [11:0] spin_ms(input logic [1:0] c);
    unique case (c)
      2'h0: spin_ms = 12'd250;
      2'h1: spin_ms = 12'd500;
      2'h2: spin_ms = 12'd1000;
      2'h3: spin_ms = 12'd2000;
    endcase
  endfunction : spin_ms

endpackage : fsltun_pkg

// ==== fsltun_glitch.sv ====
`timescale 1ns/1ps
module fsltun_glitch
  import fsltun_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_sync_b,
  // Tach path
  input  wire logic en,
  input  wire logic tach_in,
  output logic      tach_out
);

  logic [FILT_DEPTH-1:0] hist_r;

  // Sample history
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) hist_r <= '0;
    else             hist_r <= {hist_r[FILT_DEPTH-2:0], tach_in};
  end

  // Output moves only once all samples agree; spikes never do
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b)      tach_out <= 1'b0;
    else if (!en)         tach_out <= tach_in;
    else if (&hist_r)     tach_out <= 1'b1;
    else if (~|hist_r)    tach_out <= 1'b0;
  end

endmodule : fsltun_glitch

// ==== fsltun_tick.sv ====
`timescale 1ns/1ps
module fsltun_tick
  import fsltun_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_sync_b,
  // Interval select and enables out
  input  wire logic [2:0]  upd_code,
  output logic             ms_tick,
  output logic             upd_tick
);

  logic [24:0] div_r;
  logic [10:0] ms_r;

  // Millisecond divider
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_r   <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (div_r == 25'(TICKS - 1));
      div_r   <= (div_r == 25'(TICKS - 1)) ? '0 : div_r + 25'd1;
    end
  end

  // Update interval counter; a shorter new code ends the wait early
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ms_r     <= '0;
      upd_tick <= 1'b0;
    end else begin
      upd_tick <= 1'b0;
      if (ms_tick) begin
        if (ms_r + 11'd1 >= upd_ms(upd_code)) begin
          ms_r     <= '0;
          upd_tick <= 1'b1;
        end else begin
          ms_r <= ms_r + 11'd1;
        end
      end
    end
  end

endmodule : fsltun_tick

// ==== fsltun_core_asserts.sv ====
`timescale 1ns/1ps
module fsltun_core_asserts
  import fsltun_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  // Modes
  input wire logic       speed_loop_en,
  input wire logic       direct_mode_en,
  input wire logic       sw_lock,
  input wire logic       tach_valid,
  // Drive and status
  input wire logic [7:0] drive_setting,
  input wire logic       spinning_up,
  input wire logic       spin_fail_irq,
  input wire logic       drive_fail_irq,
  input wire logic       drive_fail_status
);
  // ------------------
  // Shadows
  // ------------------
  logic [1:0] age_r;
  logic       lock_r;
  logic [7:0] tune_r;
  logic [7:0] spin_r;
  logic [7:0] step_r;
  logic [7:0] prev_r;
  logic [7:0] dif;
  logic       rdy;
  logic       wok;
  assign rdy = (age_r == 2'h3);
  assign wok = reg_wr && rdy && !lock_r;
  assign dif = (drive_setting > prev_r) ? drive_setting - prev_r
                                        : prev_r - drive_setting;
  // Writes right after reset release are not taken, so wait as well
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age_r  <= 2'h0;
      lock_r <= 1'b0;
      tune_r <= RST_TUNE;
      spin_r <= RST_SPIN;
      step_r <= RST_STEP;
      prev_r <= 8'h00;
    end else begin
      prev_r <= drive_setting;
      if (!rdy) age_r <= age_r + 2'h1;
      if (sw_lock) lock_r <= 1'b1;
      if (wok && reg_addr == OFS_TUNE) tune_r <= reg_wdata;
      if (wok && reg_addr == OFS_SPIN) spin_r <= reg_wdata;
      if (wok && reg_addr == OFS_STEP) step_r <= reg_wdata & MASK_STEP;
    end
  end
  // Spin level, truncated duty
  function automatic logic [7:0] lvl(input logic [2:0] c);
    lvl = 8'((LVL_BASE_PCT + LVL_STEP_PCT * int'(c)) * 255 / 100);
  endfunction : lvl
  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_step_wback: assert property (
    wok && reg_addr == OFS_STEP ##1 reg_addr == OFS_STEP
    |-> reg_rdata == ($past(reg_wdata) & MASK_STEP)) else $error("lost");
  chk_lock_keeps: assert property (
    lock_r && reg_addr == OFS_FLOOR ##1 reg_addr == OFS_FLOOR
    |-> $stable(reg_rdata)) else $error("locked value moved");
  chk_ramp_cap: assert property (
    (rdy && !speed_loop_en && direct_mode_en && tune_r[TUNE_RAMP_BIT])[*2]
    |-> dif <= step_r) else $error("ramp step too big");
  chk_kick_full: assert property (
    rdy && $rose(spinning_up) && !spin_r[SPIN_KICK_BIT]
    |=> drive_setting == DRIVE_FULL) else $error("no full kick");
  chk_startup_drive_level: assert property (
    rdy && $rose(spinning_up) && spin_r[SPIN_KICK_BIT]
    |=> drive_setting == lvl(spin_r[4:2])) else $error("bad spin level");
  chk_fail_spin: assert property (
    spin_fail_irq |-> $past(spinning_up) && !$past(tach_valid)
    ##1 !spin_fail_irq) else $error("bad spin fail pulse");
  chk_retry_now: assert property (
    spin_fail_irq && speed_loop_en |-> spinning_up) else $error("no retry");
  chk_fail_flag: assert property (
    drive_fail_irq |-> drive_fail_status && spin_r[7:6] != 2'h0
    && $past(drive_setting) == DRIVE_FULL) else $error("bad drive fail");
endmodule : fsltun_core_asserts

// ==== fsltun_fan_model.sv ====
`timescale 1ns/1ps
module fsltun_fan_model (
  // Clock
  input  wire logic       clk,
  // Drive in, test control
  input  wire logic [7:0] drive_setting,
  input  wire logic       seized,
  // Tach side
  output logic            tach_in,
  output logic            tach_valid,
  output logic            fan_stalled
);
  logic [9:0] acc_r = 10'h000;
  // Edge rate follows duty; a seized rotor leaves the pulled-up line high
  always_ff @(posedge clk) begin
    acc_r   <= acc_r + {2'h0, drive_setting};
    tach_in <= seized ? 1'b1 : acc_r[9];
  end
  // Speed reading is good only while turning under drive
  assign tach_valid  = !seized && drive_setting != 8'h00;
  assign fan_stalled = seized;
endmodule : fsltun_fan_model

// ==== fsltun_core_tb_top.sv ====
`timescale 1ns/1ps
module fsltun_core_tb_top;
  import fsltun_pkg::*;
  localparam int TK  = 4;
  localparam int UPD = 100 * TK;
  // ------------------
  // Signals
  // ------------------
  logic clk, rst_b, reg_wr, speed_loop_en, direct_mode_en, sw_lock;
  logic below_fail_band, drive_fail_clr, seized, glitch, tach_fan;
  logic tach_in, tach_filtered, tach_valid, fan_stalled, spinning_up;
  logic spin_fail_irq, drive_fail_irq, drive_fail_status;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, direct_setting;
  logic [7:0] tach_target_hi, drive_setting, v, st, mx;
  logic [2:0] upd_code;
  logic signed [15:0] rpm_error;
  logic [15:0] lf;
  int errors, total_checks, n, k;
  logic [7:0] ADR [5] = '{OFS_TUNE, OFS_GAIN, OFS_SPIN, OFS_STEP, OFS_FLOOR};
  logic [7:0] RST [5] = '{RST_TUNE, RST_GAIN, RST_SPIN, RST_STEP, RST_FLOOR};
  logic [7:0] MSK [5] = '{MASK_TUNE, MASK_GAIN, 8'hff, MASK_STEP, 8'hff};
  assign tach_in = tach_fan ^ glitch;
  fsltun_core #(.TICKS(TK)) u_fsltun_core (.*);
  fsltun_fan_model u_fsltun_fan_model (.clk(clk),
    .drive_setting(drive_setting), .seized(seized), .tach_in(tach_fan),
    .tach_valid(tach_valid), .fan_stalled(fan_stalled));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ------------------
  // Tasks
  // ------------------
  function automatic logic [15:0] nx(input logic [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic hang(input int m);
    if (n >= m) begin
      errors++;
      $display("[ERR] wait exp done got timeout");
      give_verdict();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic wsp(input logic e, input int m);
    for (n = 0; spinning_up !== e && n < m; n++) @(negedge clk);
    hang(m);
  endtask : wsp
  // One spin attempt: full-duty cycles, peak drive, length
  task automatic attempt();
    k  = 0;
    mx = 8'h00;
    @(negedge clk);
    for (n = 0; spin_fail_irq !== 1'b1 && n < 2000; n++) begin
      @(negedge clk);
      if (drive_setting === 8'hff) k++;
      if (drive_setting > mx) mx = drive_setting;
    end
    hang(2000);
  endtask : attempt
  task automatic glt(input logic [7:0] e);
    @(posedge clk);
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    mx = 8'h00;
    repeat (8) begin
      @(negedge clk);
      if (tach_filtered === 1'b0) mx = 8'h01;
    end
    chk("tach_filtered", e, mx);
  endtask : glt
  // ------------------
  // Sequence
  // ------------------
  initial begin
    {rst_b, reg_wr, speed_loop_en, direct_mode_en, sw_lock, glitch} = '0;
    {below_fail_band, drive_fail_clr, reg_addr, reg_wdata} = '0;
    {seized, tach_target_hi, upd_code, direct_setting} = {1'b1, 8'h80, 11'h0};
    rpm_error = '0;
    {errors, total_checks, lf} = {32'd0, 32'd0, 16'd71};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(ADR[i]);
      chk("reset", RST[i], v);
      lf = nx(lf);
      wr(ADR[i], lf[7:0]);
      rd(ADR[i]);
      chk("readback", lf[7:0] & MSK[i], v);
    end
    rd(8'h44);
    chk("unmapped", 8'h00, v);
    wr(OFS_SPIN, 8'h58);
    wr(OFS_STEP, 8'h05);
    wr(OFS_FLOOR, 8'h66);
    wr(OFS_TUNE, 8'h20);
    glt(8'h00);
    wr(OFS_TUNE, 8'h00);
    glt(8'h01);
    // Direct mode, limiter off: new value lands at once
    repeat (4) begin
      lf = nx(lf);
      @(posedge clk);
      direct_mode_en <= 1'b1;
      direct_setting <= lf[7:0];
      repeat (3) @(negedge clk);
      chk("direct", lf[7:0], drive_setting);
    end
    wr(OFS_TUNE, 8'h60);
    @(negedge clk);
    st = drive_setting;
    @(posedge clk);
    direct_setting <= st ^ 8'h80;
    for (n = 0; drive_setting === st && n < 3 * UPD; n++) @(negedge clk);
    chk("ramp", st[7] ? st - 8'h05 : st + 8'h05, drive_setting);
    // Seized fan: kick, timeout pulse, immediate retry
    @(posedge clk);
    direct_mode_en <= 1'b0;
    speed_loop_en  <= 1'b1;
    attempt();
    chk("kick", 8'h01, {7'h0, k > 236 && k < 264});
    chk("spin_time", 8'h01, {7'h0, n > 985 && n < 1015});
    chk("retry", 8'h01, {7'h0, spinning_up});
    wr(OFS_SPIN, 8'h7c);
    attempt();
    attempt();
    chk("no_kick", 8'ha5, mx);
    @(posedge clk);
    seized <= 1'b0;
    wsp(1'b0, 2200);
    @(posedge clk);
    seized <= 1'b1;
    wsp(1'b1, 20);
    chk("restart", 8'h01, {7'h0, spinning_up});
    @(posedge clk);
    seized <= 1'b0;
    wsp(1'b0, 2200);
    // Deadband of 200: small error holds, larger one moves
    wr(OFS_TUNE, 8'h26);
    @(posedge clk);
    rpm_error <= 16'sd150;
    @(negedge clk);
    st = drive_setting;
    repeat (3 * UPD) @(negedge clk);
    chk("deadband", st, drive_setting);
    @(posedge clk);
    rpm_error <= 16'sd250;
    repeat (2 * UPD) @(negedge clk);
    chk("outside", 8'h01, {7'h0, drive_setting > st});
    // Too fast: drive sinks to the floor and stays there
    wr(OFS_TUNE, 8'h20);
    @(posedge clk);
    rpm_error <= -16'sd1000;
    mx = 8'hff;
    repeat (24 * UPD) begin
      @(negedge clk);
      if (drive_setting < mx) mx = drive_setting;
    end
    chk("floor", 8'h66, mx);
    @(posedge clk);
    rpm_error <= 16'sd8000;
    below_fail_band <= 1'b1;
    for (n = 0; drive_setting !== 8'hff && n < 40 * UPD; n++) @(negedge clk);
    hang(40 * UPD);
    for (n = 0; drive_fail_irq !== 1'b1 && n < 20 * UPD; n++) @(negedge clk);
    hang(20 * UPD);
    chk("fail_time", 8'h01, {7'h0, n > 14 * UPD && n <= 17 * UPD});
    chk("fail_flag", 8'h01, {7'h0, drive_fail_status});
    @(posedge clk);
    below_fail_band <= 1'b0;
    drive_fail_clr  <= 1'b1;
    @(posedge clk);
    drive_fail_clr  <= 1'b0;
    @(negedge clk);
    chk("fail_clear", 8'h00, {7'h0, drive_fail_status});
    @(posedge clk);
    tach_target_hi <= 8'hff;
    repeat (3) @(negedge clk);
    chk("target_off", 8'h00, drive_setting);
    // Lock holds until a reset in mid-run clears it
    @(posedge clk);
    sw_lock <= 1'b1;
    @(posedge clk);
    sw_lock <= 1'b0;
    wr(OFS_FLOOR, 8'h11);
    rd(OFS_FLOOR);
    chk("locked", 8'h66, v);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OFS_FLOOR, 8'h11);
    rd(OFS_FLOOR);
    chk("unlocked", 8'h11, v);
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("[ERR] run exp end got timeout");
    give_verdict();
  end
endmodule : fsltun_core_tb_top
bind fsltun_core fsltun_core_asserts u_fsltun_core_asserts (.*);
